// [hdl/sfc_pkg.sv]
// shared constants, frame layout and crc for the serial frame crc link
package sfc_pkg;
  localparam int FRAME_PLAIN_BITS = 16;
  localparam int FRAME_CRC_BITS = 24;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // frame word fields
  localparam int F_ADDR_HI = 15;
  localparam int F_ADDR_LO = 13;
  localparam int F_RW = 12;
  localparam int F_SW_CLEAR = 11;
  localparam int F_RANGE_HI = 10;
  localparam int F_RANGE_LO = 7;
  localparam int F_CLEAR_LEVEL_SELECT = 6;
  localparam int F_OUTEN = 5;
  localparam int F_SENSE_RESISTOR_SELECT = 4;
  // status bit positions
  localparam int S_FRAME_ERR = 3;
  localparam int S_OVER_TEMP = 2;
  localparam int S_CUR_FAULT = 1;
  localparam int S_VOLT_FAULT = 0;
  // output codes for the clear levels
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  // reset values of the device control word
  localparam logic [3:0] RANGE_RST = 4'h0;
  localparam logic CLEAR_LEVEL_SELECT_RST = 1'b0;
  localparam logic OUTEN_RST = 1'b0;
  localparam logic SENSE_RESISTOR_SELECT_RST = 1'b1;
  // range codes with special bipolar and overrange handling
  localparam logic [3:0] RNG_CUR_PM20 = 4'hb;
  localparam logic [3:0] RNG_CUR_PM24 = 4'hc;
  localparam logic [3:0] RNG_CUR_OVR_FIRST = 4'hd;
  // host register map (byte addresses)
  localparam logic [3:0] REG_TXDATA = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RXDATA = 4'hc;
  localparam int CMD_START = 0;
  localparam int CMD_CRC_EN = 1;
  // link timing derived from the system clock
  localparam int CLK_PERIOD_PS = 4000;
  localparam int LINK_PERIOD_PS = 125000;
  localparam int SCLK_HALF_CYC = (LINK_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_SETUP = 3'b001,
    HS_HIGH = 3'b011,
    HS_LOW = 3'b010,
    HS_END = 3'b110,
    HS_GAP = 3'b111
  } sfc_host_state_t;

  function automatic logic [7:0] sfc_crc8(input logic [15:0] data);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      fb = c[7] ^ data[i];
      c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction : sfc_crc8
endpackage : sfc_pkg

// [hdl/sfc_link_if.sv]
// serial link between host controller and output driver control slice
`timescale 1ns/1ps
`default_nettype none
interface sfc_link_if;
  logic sclk;
  logic sdin;
  logic sync_n;
  logic sdo_o;
  logic sdo_oe;
  logic sdo;
  logic fault_oe;
  logic fault_n;
  // pulled-up lines: undriven reads high
  assign sdo = sdo_oe ? sdo_o : 1'b1;
  assign fault_n = fault_oe ? 1'b0 : 1'b1;
  modport dev (input sclk, input sdin, input sync_n, output sdo_o, output sdo_oe, output fault_oe);
  modport host (output sclk, output sdin, output sync_n, input sdo, input fault_n);
endinterface : sfc_link_if
`default_nettype wire

// [hdl/sfc_dev.sv]
// device end: frame receiver, crc check, status, clear and range control
`timescale 1ns/1ps
`default_nettype none
module sfc_dev #(
  parameter logic [2:0] DEV_ADDR = 3'h0
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  sfc_link_if.dev link,
  input wire logic clear_in,
  input wire logic clear_level_select_in,
  input wire logic hw_mode_in,
  input wire logic [3:0] range_pins_in,
  input wire logic sense_resistor_select_pin_in,
  input wire logic over_temp_in,
  input wire logic current_fault_in,
  input wire logic voltage_fault_in,
  output logic clear_active_out,
  output logic [15:0] clear_code_out,
  output logic [3:0] range_code_out,
  output logic current_mode_out,
  output logic bipolar_out,
  output logic overrange_out,
  output logic sense_resistor_select_out,
  output logic output_enable_out,
  output logic frame_error_out
);
  import sfc_pkg::*;

  localparam int NSYNC = 14;
  // link clock and frame select reset to their idle high level, so no false edge follows reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 14'h2800;

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  logic sclk_d1_q;
  logic sync_n_d1_q;
  logic sclk_s;
  logic sdin_s;
  logic sync_n_s;
  logic clear_s;
  logic clear_level_select_pin_s;
  logic hw_s;
  logic [3:0] range_pins_s;
  logic sense_resistor_select_pin_s;
  logic ot_s;
  logic if_s;
  logic vf_s;
  logic sclk_fall;
  logic sclk_rise;
  logic frame_start;
  logic frame_end;

  logic [23:0] shift_q;
  logic [4:0] count_q;
  logic [15:0] word;
  logic [7:0] rx_crc;
  logic addr_ok;
  logic crc_ok;
  logic commit;
  logic crc_fail;
  logic read_cmd;

  logic [3:0] range_q;
  logic clear_level_select_q;
  logic outen_q;
  logic sense_resistor_select_q;
  logic sw_clear_q;
  logic err_q;
  logic read_armed_q;
  logic [15:0] sdo_shift_q;
  logic sdo_oe_q;
  logic [15:0] status_word;
  logic [3:0] range_eff;
  logic clear_level_select_eff;
  logic fault_any;

  assign async_in = {link.sclk, link.sdin, link.sync_n, clear_in, clear_level_select_in, hw_mode_in,
                     range_pins_in, sense_resistor_select_pin_in, over_temp_in, current_fault_in,
                     voltage_fault_in};

  // every pin passes two flops; only the second stage is read
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= SYNC_IDLE;
      sync_q <= SYNC_IDLE;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign {sclk_s, sdin_s, sync_n_s, clear_s, clear_level_select_pin_s, hw_s, range_pins_s, sense_resistor_select_pin_s, ot_s, if_s,
          vf_s} = sync_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_d1_q <= 1'b1;
      sync_n_d1_q <= 1'b1;
    end else begin
      sclk_d1_q <= sclk_s;
      sync_n_d1_q <= sync_n_s;
    end
  end

  assign sclk_fall = sclk_d1_q && !sclk_s && !sync_n_s;
  assign sclk_rise = !sclk_d1_q && sclk_s && !sync_n_s;
  assign frame_start = sync_n_d1_q && !sync_n_s;
  assign frame_end = !sync_n_d1_q && sync_n_s;

  // data bit taken on each falling clock
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift_q <= 24'h000000;
      count_q <= 5'h00;
    end else if (frame_start) begin
      count_q <= 5'h00;
    end else if (sclk_fall) begin
      shift_q <= {shift_q[22:0], sdin_s};
      if (count_q != 5'h1f) begin
        count_q <= count_q + 5'h01;
      end
    end
  end

  // a crc frame carries the word ahead of its check byte
  assign word = (count_q == 5'(FRAME_CRC_BITS)) ? shift_q[23:8] : shift_q[15:0];
  assign rx_crc = shift_q[7:0];
  assign addr_ok = word[F_ADDR_HI:F_ADDR_LO] == DEV_ADDR;
  // check made at frame select rise
  assign crc_ok = sfc_crc8(word) == rx_crc;
  // commit on match; plain frames skip the check
  assign commit = frame_end && addr_ok &&
                  ((count_q == 5'(FRAME_PLAIN_BITS)) || ((count_q == 5'(FRAME_CRC_BITS)) && crc_ok));
  assign crc_fail = frame_end && (count_q == 5'(FRAME_CRC_BITS)) && !crc_ok;
  assign read_cmd = commit && word[F_RW];

  // resistor select and range bits loaded from the word
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      range_q <= RANGE_RST;
      clear_level_select_q <= CLEAR_LEVEL_SELECT_RST;
      outen_q <= OUTEN_RST;
      sense_resistor_select_q <= SENSE_RESISTOR_SELECT_RST;
      sw_clear_q <= 1'b0;
    end else if (commit && !word[F_RW]) begin
      range_q <= word[F_RANGE_HI:F_RANGE_LO];
      clear_level_select_q <= word[F_CLEAR_LEVEL_SELECT];
      outen_q <= word[F_OUTEN];
      sense_resistor_select_q <= word[F_SENSE_RESISTOR_SELECT];
      // clear command held until written off
      sw_clear_q <= word[F_SW_CLEAR];
    end
  end

  // status word layout, error flag at bit 3
  assign status_word = {DEV_ADDR, 1'b1, 1'b0, range_q, clear_level_select_q, outen_q, sense_resistor_select_q, err_q, ot_s, if_s, vf_s};

  // crc failure sets flag; status read clears it, set wins
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      err_q <= 1'b0;
    end else if (crc_fail) begin
      err_q <= 1'b1;
    end else if (read_cmd) begin
      err_q <= 1'b0;
    end
  end

  // status snapshot at read commit goes out on the next frame
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      read_armed_q <= 1'b0;
      sdo_shift_q <= 16'h0000;
    end else begin
      if (read_cmd) begin
        read_armed_q <= 1'b1;
        sdo_shift_q <= status_word;
      end else if (frame_start && read_armed_q) begin
        read_armed_q <= 1'b0;
      end else if (sclk_rise && sdo_oe_q) begin
        sdo_shift_q <= {sdo_shift_q[14:0], 1'b0};
      end
    end
  end

  // driver released at every frame end, even when that frame arms the next readback
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sdo_oe_q <= 1'b0;
    end else if (frame_start && read_armed_q) begin
      sdo_oe_q <= 1'b1;
    end else if (frame_end) begin
      sdo_oe_q <= 1'b0;
    end
  end

  assign link.sdo_o = sdo_shift_q[15];
  assign link.sdo_oe = sdo_oe_q;

  // any fault pulls the shared line low
  assign fault_any = err_q || ot_s || if_s || vf_s;
  assign link.fault_oe = fault_any;
  assign frame_error_out = err_q;

  // pins in hardware mode, register bits otherwise
  assign range_eff = hw_s ? range_pins_s : range_q;
  // level select is pin OR bit
  assign clear_level_select_eff = clear_level_select_pin_s || clear_level_select_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      range_code_out <= RANGE_RST;
      current_mode_out <= 1'b0;
      bipolar_out <= 1'b0;
      overrange_out <= 1'b0;
      sense_resistor_select_out <= SENSE_RESISTOR_SELECT_RST;
      output_enable_out <= OUTEN_RST;
    end else begin
      range_code_out <= range_eff;
      current_mode_out <= range_eff[3];
      bipolar_out <= range_eff[3] ? (range_eff == RNG_CUR_PM20 || range_eff == RNG_CUR_PM24) : range_eff[1];
      // voltage codes with bit 2 are the extended ranges
      // current overrange only on codes above the bipolar ones
      overrange_out <= range_eff[3] ? (range_eff >= RNG_CUR_OVR_FIRST) : range_eff[2];
      // resistor select follows the pin in hardware mode, the shifted bit otherwise
      sense_resistor_select_out <= hw_s ? sense_resistor_select_pin_s : sense_resistor_select_q;
      output_enable_out <= outen_q;
    end
  end

  // pin or command forces clear; release restores the set value
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clear_active_out <= 1'b0;
      clear_code_out <= CODE_ZERO;
    end else begin
      clear_active_out <= clear_s || sw_clear_q;
      // code zero is bottom or negative full scale
      clear_code_out <= clear_level_select_eff ? CODE_MID : CODE_ZERO;
    end
  end
endmodule : sfc_dev
`default_nettype wire

// [hdl/sfc_host.sv]
// host end: ahb-lite registers driving the serial frame link
`timescale 1ns/1ps
`default_nettype none
module sfc_host #(
  parameter int HALF_CYC = sfc_pkg::SCLK_HALF_CYC
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  sfc_link_if.host link,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out
);
  import sfc_pkg::*;

  // readback bit needs two device syncs, its shift flop and our two syncs within one half period
  if (HALF_CYC < 6 || HALF_CYC > 255) begin : g_half_check
    $error("HALF_CYC out of range");
  end

  sfc_host_state_t state_q;
  logic [7:0] tick_q;
  logic [4:0] bit_q;
  logic [4:0] nbits_q;
  logic [23:0] tx_q;
  logic [15:0] txdata_q;
  logic crc_en_q;
  logic [15:0] rx_q;
  logic [1:0] sdo_sync_q;
  logic [1:0] fault_sync_q;
  logic ap_wr_q;
  logic ap_rd_q;
  logic [3:0] ap_addr_q;
  logic start;
  logic tick_done;
  logic busy;
  logic crc_now;

  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ap_wr_q <= 1'b0;
      ap_rd_q <= 1'b0;
      ap_addr_q <= 4'h0;
    end else if (hready_in) begin
      ap_wr_q <= hsel_in && htrans_in[1] && hwrite_in;
      ap_rd_q <= hsel_in && htrans_in[1] && !hwrite_in;
      ap_addr_q <= haddr_in[3:0];
    end
  end

  assign busy = state_q != HS_IDLE;
  assign start = ap_wr_q && ap_addr_q == REG_CMD && hwdata_in[CMD_START] && !busy;
  // a start written together with the crc bit uses that bit, not the old one
  assign crc_now = (ap_wr_q && ap_addr_q == REG_CMD && !busy) ? hwdata_in[CMD_CRC_EN] : crc_en_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      txdata_q <= 16'h0000;
      crc_en_q <= 1'b0;
    end else if (ap_wr_q && !busy) begin
      if (ap_addr_q == REG_TXDATA) begin
        txdata_q <= hwdata_in[15:0];
      end
      if (ap_addr_q == REG_CMD) begin
        crc_en_q <= hwdata_in[CMD_CRC_EN];
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hrdata_out <= 32'h00000000;
    end else if (hsel_in && htrans_in[1] && !hwrite_in && hready_in) begin
      unique case (haddr_in[3:0])
        REG_TXDATA: hrdata_out <= {16'h0000, txdata_q};
        REG_CMD: hrdata_out <= {30'h00000000, crc_en_q, 1'b0};
        REG_STATUS: hrdata_out <= {30'h00000000, !fault_sync_q[1], busy};
        REG_RXDATA: hrdata_out <= {16'h0000, rx_q};
        default: hrdata_out <= 32'h00000000;
      endcase
    end
  end

  // sdo and fault come from the far side
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sdo_sync_q <= 2'b11;
      fault_sync_q <= 2'b11;
    end else begin
      sdo_sync_q <= {sdo_sync_q[0], link.sdo};
      fault_sync_q <= {fault_sync_q[0], link.fault_n};
    end
  end

  assign tick_done = tick_q == 8'(HALF_CYC - 1);

  // host drives clock, data and frame select
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= HS_IDLE;
      tick_q <= 8'h00;
      bit_q <= 5'h00;
      nbits_q <= 5'h00;
      tx_q <= 24'h000000;
      rx_q <= 16'h0000;
      link.sclk <= 1'b1;
      link.sdin <= 1'b0;
      link.sync_n <= 1'b1;
    end else begin
      tick_q <= (tick_done || state_q == HS_IDLE) ? 8'h00 : tick_q + 8'h01;
      unique case (state_q)
        HS_IDLE: begin
          if (start) begin
            // with crc on, crc-8 on the word appended and 24 bits sent; 16 bits otherwise
            tx_q <= crc_now ? {txdata_q, sfc_crc8(txdata_q)} : {txdata_q, 8'h00};
            nbits_q <= crc_now ? 5'(FRAME_CRC_BITS) : 5'(FRAME_PLAIN_BITS);
            bit_q <= 5'h00;
            link.sync_n <= 1'b0;
            state_q <= HS_SETUP;
          end
        end
        HS_SETUP: begin
          if (tick_done) begin
            link.sdin <= tx_q[23];
            tx_q <= {tx_q[22:0], 1'b0};
            state_q <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          // data stands across the falling edge
          if (tick_done) begin
            link.sclk <= 1'b0;
            rx_q <= {rx_q[14:0], sdo_sync_q[1]};
            bit_q <= bit_q + 5'h01;
            state_q <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (tick_done) begin
            link.sclk <= 1'b1;
            if (bit_q == nbits_q) begin
              state_q <= HS_END;
            end else begin
              link.sdin <= tx_q[23];
              tx_q <= {tx_q[22:0], 1'b0};
              state_q <= HS_HIGH;
            end
          end
        end
        HS_END: begin
          if (tick_done) begin
            link.sync_n <= 1'b1;
            state_q <= HS_GAP;
          end
        end
        HS_GAP: begin
          if (tick_done) begin
            state_q <= HS_IDLE;
          end
        end
      endcase
    end
  end
endmodule : sfc_host
`default_nettype wire

// [bench/sfc_link_assertions.sv]
// protocol checks on the serial link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module sfc_link_assertions (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic sync_n,
  input wire logic sdo_oe,
  input wire logic sdo,
  input wire logic fault_n
);
  logic [5:0] falls_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // clock falls per frame, cleared while frame select is idle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      falls_q <= 6'h00;
    end else if (sync_n) begin
      falls_q <= 6'h00;
    end else if ($fell(sclk)) begin
      falls_q <= falls_q + 6'h01;
    end
  end
  a_frame_bit_count: assert property ($rose(sync_n) |-> falls_q == 6'd16 || falls_q == 6'd24)
    else $error("frame length is neither 16 nor 24 bits");
  a_data_at_fall: assert property ($fell(sclk) |-> $stable(sdin))
    else $error("data changed on the link clock fall");
  a_clock_idle_high: assert property (sync_n |-> sclk)
    else $error("link clock low outside a frame");
  a_select_rise_high: assert property ($rose(sync_n) |-> sclk && $past(sclk))
    else $error("frame select rose with the link clock low");
  a_frame_gap: assert property ($rose(sync_n) |=> sync_n [*3])
    else $error("gap between frames too short");
  a_clock_high_half: assert property ($rose(sclk) |=> sclk [*3])
    else $error("link clock high phase too short");
  a_clock_low_half: assert property ($fell(sclk) |=> !sclk [*3])
    else $error("link clock low phase too short");
  a_readback_in_frame: assert property ($rose(sdo_oe) |-> !sync_n)
    else $error("readback driver enabled outside a frame");
  a_readback_release: assert property ($rose(sync_n) |-> ##[0:8] !sdo_oe)
    else $error("readback driver not released after frame");
  a_readback_steady: assert property (sdo_oe && !sync_n && $fell(sclk) |-> $stable(sdo))
    else $error("readback data moved at the link clock fall");
  a_fault_level_hold: assert property ($fell(fault_n) |=> !fault_n [*4])
    else $error("fault line not held low");
endmodule : sfc_link_assertions
`default_nettype wire

// [bench/test_serial_frame_crc_and_clear_control.sv]
// self-checking bench: host and device ends joined over the serial link
`timescale 1ns/1ps
`default_nettype none
module test_serial_frame_crc_and_clear_control;
  import sfc_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic clr = 1'b0;
  logic clr_sel = 1'b0;
  logic hw_mode = 1'b0;
  logic sense_resistor_select_pin = 1'b0;
  logic over_temp = 1'b0;
  logic [3:0] rng_pins = 4'h0;
  logic [2:0] hsize = 3'h0;
  logic cur_fault = 1'b0;
  logic clr_act, ovr, bip, cur, sense_resistor_select, outen, ferr, ferr2;
  logic [15:0] clr_code;
  logic [3:0] rng, rng2;
  logic [31:0] rd;
  logic [15:0] rx;
  int miscompares = 0;
  int checks_done = 0;
  sfc_link_if sfc_link_if_inst ();
  // second link: bench drives it in the host's place to inject bad frames
  sfc_link_if sfc_link_if_inst2 ();
  always #2 clk_in = ~clk_in;
  // short half period keeps frames short, yet leaves the readback bit time to settle
  sfc_host #(.HALF_CYC(8)) sfc_host_inst (.clk_in(clk_in), .nrst_in(nrst_in), .link(sfc_link_if_inst.host),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready), .hresp_out(), .hrdata_out(hrdata));
  sfc_dev sfc_dev_inst (.clk_in(clk_in), .nrst_in(nrst_in), .link(sfc_link_if_inst.dev), .clear_in(clr),
    .clear_level_select_in(clr_sel), .hw_mode_in(hw_mode), .range_pins_in(rng_pins),
    .sense_resistor_select_pin_in(sense_resistor_select_pin), .over_temp_in(over_temp), .current_fault_in(cur_fault),
    .voltage_fault_in(1'b0), .clear_active_out(clr_act), .clear_code_out(clr_code), .range_code_out(rng),
    .current_mode_out(cur), .bipolar_out(bip), .overrange_out(ovr), .sense_resistor_select_out(sense_resistor_select),
    .output_enable_out(outen), .frame_error_out(ferr));
  sfc_dev sfc_dev_inst2 (.clk_in(clk_in), .nrst_in(nrst_in), .link(sfc_link_if_inst2.dev), .clear_in(clr),
    .clear_level_select_in(clr_sel), .hw_mode_in(hw_mode), .range_pins_in(rng_pins),
    .sense_resistor_select_pin_in(sense_resistor_select_pin), .over_temp_in(over_temp), .current_fault_in(1'b0),
    .voltage_fault_in(1'b0), .clear_active_out(), .clear_code_out(), .range_code_out(rng2),
    .current_mode_out(), .bipolar_out(), .overrange_out(), .sense_resistor_select_out(),
    .output_enable_out(), .frame_error_out(ferr2));
  sfc_link_assertions sfc_link_assertions_inst (.clk_in(clk_in), .nrst_in(nrst_in), .sclk(sfc_link_if_inst.sclk),
    .sdin(sfc_link_if_inst.sdin), .sync_n(sfc_link_if_inst.sync_n), .sdo_oe(sfc_link_if_inst.sdo_oe),
    .sdo(sfc_link_if_inst.sdo), .fault_n(sfc_link_if_inst.fault_n));

  task results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      results();
    end
  endtask : wait_rdy

  task ahb(input logic wr, input logic [3:0] addr, input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk_in);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {28'h0, addr};
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
  endtask : ahb

  task host_frame(input logic [15:0] w, input logic crc);
    int k;
    ahb(1'b1, REG_TXDATA, {16'h0, w}, rd);
    ahb(1'b1, REG_CMD, {30'h0, crc, 1'b1}, rd);
    k = 0;
    do begin
      ahb(1'b0, REG_STATUS, 32'h0, rd);
      k++;
    end while (rd[0] !== 1'b0 && k < 400);
    if (k >= 400) begin
      miscompares++;
      results();
    end
    repeat (8) @(posedge clk_in);
  endtask : host_frame

  // halves of 16 or 15 clocks, five and three in every eight, average a 125 ns link period
  task half_wait(inout int h);
    repeat ((h % 8 == 3 || h % 8 == 5 || h % 8 == 7) ? 15 : 16) @(posedge clk_in);
    h++;
  endtask : half_wait

  // bench plays host on the second link; every change lands right after a clock edge
  task bang(input logic [23:0] w, input int n);
    int h;
    h = 0;
    rx = 16'h0;
    @(posedge clk_in);
    sfc_link_if_inst2.sync_n <= 1'b0;
    sfc_link_if_inst2.sdin <= w[23];
    for (int i = 0; i < n; i++) begin
      half_wait(h);
      sfc_link_if_inst2.sclk <= 1'b0;
      rx = {rx[14:0], sfc_link_if_inst2.sdo};
      half_wait(h);
      sfc_link_if_inst2.sclk <= 1'b1;
      if (i < n - 1) begin
        sfc_link_if_inst2.sdin <= w[22 - i];
      end
    end
    half_wait(h);
    sfc_link_if_inst2.sync_n <= 1'b1;
    repeat (50) @(posedge clk_in);
  endtask : bang

  task crc_fault_scenario;
    // check byte of 0180 under x^8+x^2+x+1 is 9c, 9d is corrupt
    bang({16'h0180, 8'h9d}, 24);
    chk(ferr2, 1'b1);
    chk(sfc_link_if_inst2.fault_n, 1'b0);
    chk(rng2, 4'h0);
    bang({16'h0180, 8'h9c}, 24);
    chk(rng2, 4'h3);
    chk(ferr2, 1'b1);
    bang({16'h1000, 8'h00}, 16);
    chk(ferr2, 1'b0);
    chk(sfc_link_if_inst2.fault_n, 1'b1);
    bang({16'h1000, 8'h00}, 16);
    chk(rx, 16'h1188);
  endtask : crc_fault_scenario

  task fault_scenario;
    over_temp <= 1'b1;
    repeat (12) @(posedge clk_in);
    chk(sfc_link_if_inst.fault_n, 1'b0);
    over_temp <= 1'b0;
    repeat (12) @(posedge clk_in);
    chk(sfc_link_if_inst.fault_n, 1'b1);
    cur_fault <= 1'b1;
    repeat (12) @(posedge clk_in);
    chk(sfc_link_if_inst.fault_n, 1'b0);
    ahb(1'b0, REG_STATUS, 32'h0, rd);
    chk(rd[1], 1'b1);
    cur_fault <= 1'b0;
    repeat (12) @(posedge clk_in);
    ahb(1'b0, REG_STATUS, 32'h0, rd);
    chk({sfc_link_if_inst.fault_n, rd[1]}, 2'b10);
  endtask : fault_scenario

  task range_scenario;
    logic [3:0] r;
    for (int i = 0; i < 16; i++) begin
      r = i[3:0];
      host_frame({5'h00, r, 2'b01, r[0], 4'h0}, r[1]);
      chk(rng, r);
      chk(cur, r[3]);
      chk(bip, r[3] ? (r == 4'hb || r == 4'hc) : r[1]);
      chk(ovr, (r >= 4'h4 && r <= 4'h7) || r >= 4'hd);
      chk(sense_resistor_select, r[0]);
      chk({outen, ferr}, 2'b10);
    end
    hw_mode <= 1'b1;
    rng_pins <= 4'ha;
    repeat (8) @(posedge clk_in);
    chk({rng, sense_resistor_select}, {4'ha, 1'b0});
    hw_mode <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk({rng, sense_resistor_select}, {4'hf, 1'b1});
  endtask : range_scenario

  task clear_scenario;
    clr <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk({clr_act, clr_code}, {1'b1, CODE_ZERO});
    clr_sel <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk({clr_act, clr_code}, {1'b1, CODE_MID});
    host_frame(16'h0120, 1'b0);
    clr <= 1'b0;
    clr_sel <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk({clr_act, rng}, {1'b0, 4'h2});
    host_frame(16'h0860, 1'b1);
    chk({clr_act, clr_code}, {1'b1, CODE_MID});
    host_frame(16'h0020, 1'b0);
    chk(clr_act, 1'b0);
  endtask : clear_scenario

  initial begin
    sfc_link_if_inst2.sclk = 1'b1;
    sfc_link_if_inst2.sdin = 1'b0;
    sfc_link_if_inst2.sync_n = 1'b1;
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk({clr_act, clr_code, rng, sense_resistor_select, outen}, {1'b0, CODE_ZERO, RANGE_RST, SENSE_RESISTOR_SELECT_RST, OUTEN_RST});
    host_frame(16'h1000, 1'b0);
    host_frame(16'h1000, 1'b0);
    ahb(1'b0, REG_RXDATA, 32'h0, rd);
    chk(rd[15:0], 16'h1010);
    crc_fault_scenario();
    range_scenario();
    clear_scenario();
    fault_scenario();
    results();
  end
endmodule : test_serial_frame_crc_and_clear_control
`default_nettype wire
